/* hdl/krpg_regs.sv */
// Function
// [R01] Next-page low word used only when enabled
// [R02] Next-page low: NP, ACK, MP, SECOND_ACKNOWLEDGE, toggle; ACK (page bit 14) is sent as zero, not taken from the word
// [R03] Next-page high maps to page 47:16
// [R04] Page bit 49 generated internally only
// [R05] Partner base low holds received fields
// [R06] Partner base high: tech and nonce
// [R07] Partner next-page low holds bits 15:11
// [R08] Partner next-page high: page 47:16
// [R09] Advertisement 24:0 reports technology field
// [R10] Only A0 and A2 supported here
// [R11] Advertisement 26:25 report FEC bits
// [R12] Advertisement 27 reports remote fault
// [R13] Advertisement 30:28 report pause bits
// [R14] Training enable bit, reset one
// [R15] Max-wait timer disable bit, reset zero
// [R16] Main steps field, reset one, 1-15; a written 0 is stored and driven unchanged
// [R17] Pre/post steps field, reset one
// [R18] Partner registers update on full pages
`include "krpg_params.svh"

module krpg_regs
(
    input  wire logic                   aclk,          // Clock, 40 MHz
    input  wire logic                   aresetn,       // Synchronous reset, active low
    input  wire logic [13:0]            s_awaddr,      // Write address
    input  wire logic [2:0]             s_awprot,      // Write protection, unused
    input  wire logic                   s_awvalid,     // Write address valid
    output logic                        s_awready,     // Write address ready
    input  wire logic [31:0]            s_wdata,       // Write data
    input  wire logic [3:0]             s_wstrb,       // Write byte strobes
    input  wire logic                   s_wvalid,      // Write data valid
    output logic                        s_wready,      // Write data ready
    output logic [1:0]                  s_bresp,       // Write response
    output logic                        s_bvalid,      // Write response valid
    input  wire logic                   s_bready,      // Write response ready
    input  wire logic [13:0]            s_araddr,      // Read address
    input  wire logic [2:0]             s_arprot,      // Read protection, unused
    input  wire logic                   s_arvalid,     // Read address valid
    output logic                        s_arready,     // Read address ready
    output logic [31:0]                 s_rdata,       // Read data
    output logic [1:0]                  s_rresp,       // Read response
    output logic                        s_rvalid,      // Read data valid
    input  wire logic                   s_rready,      // Read data ready
    input  wire krpg_pkg::krpg_rx_page_t rx_page,      // Page from receive state machine
    input  wire logic                   tx_prbs,       // Pseudo-random bit from transmit side
    output krpg_pkg::krpg_tx_page_t     tx_page,       // Next page to transmit
    output krpg_pkg::krpg_lt_ctrl_t     lt_ctrl,       // Training controls
    output logic [24:0]                 supported_tech // Partner techs this PHY can use
);

    // Writable registers
    logic [15:0] tx_np_low_q,  tx_np_low_d;   // User next page low
    logic [31:0] tx_np_high_q, tx_np_high_d;  // User next page high
    logic [31:0] lt_ctrl_q,    lt_ctrl_d;     // Training control
    logic        np_en_q,      np_en_d;       // Next-page control bit
    // Captured partner pages
    logic [15:0] lp_base_low_q,  lp_base_low_d;  // Partner base low
    logic [31:0] lp_base_high_q, lp_base_high_d; // Partner base high
    logic [15:0] lp_np_low_q,    lp_np_low_d;    // Partner next low
    logic [31:0] lp_np_high_q,   lp_np_high_d;   // Partner next high
    logic [1:0]  lp_fec_q,       lp_fec_d;       // Partner FEC ability and request
    // Bus state
    logic        aw_held_q, aw_held_d;        // Write address captured
    logic        w_held_q,  w_held_d;         // Write data captured
    logic [11:0] aw_idx_q,  aw_idx_d;         // Captured write index
    logic [31:0] wdata_q,   wdata_d;          // Captured write data
    logic [3:0]  wstrb_q,   wstrb_d;          // Captured strobes
    logic        bvalid_q,  bvalid_d;         // Write response pending
    logic [1:0]  bresp_q,   bresp_d;          // Write response code
    logic        rvalid_q,  rvalid_d;         // Read data pending
    logic [31:0] rdata_q,   rdata_d;          // Read data
    logic [1:0]  rresp_q,   rresp_d;          // Read response code
    logic        do_write;                    // Write commits this cycle
    logic [31:0] rd_val;                      // Decoded read value
    logic        rd_hit;                      // Read index mapped
    logic [31:0] adv_word;                    // Partner advertisement word

    // Merge write data into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Index compare
    function automatic logic idx_is(input logic [11:0] idx, input logic [11:0] ref_idx);
        return idx == ref_idx;
    endfunction

    // Advertisement word assembled from the captured base page
    always_comb
    begin
        adv_word        = 32'h0000_0000;
        adv_word[24:0]  = lp_base_high_q[29:5];              // R09
        adv_word[25]    = lp_fec_q[0];                       // R11
        adv_word[26]    = lp_fec_q[1];                       // R11
        adv_word[27]    = lp_base_low_q[13];                 // R12
        adv_word[28]    = lp_base_low_q[10];                 // R13
        adv_word[29]    = lp_base_low_q[11];                 // R13
        adv_word[30]    = lp_base_low_q[12];                 // R13
    end

    // Only 1000BASE-KX and 10GBASE-KR abilities are usable by this PHY
    always_comb
    begin
        supported_tech    = 25'h0000000;
        supported_tech[0] = adv_word[0];                     // R10
        supported_tech[2] = adv_word[2];                     // R10
    end

    // Next page toward the transmit side
    always_comb
    begin
        tx_page.use_np       = np_en_q;                      // R01
        tx_page.page         = '0;
        if (np_en_q)
        begin
            tx_page.page[15:11] = {tx_np_low_q[15], 1'b0, tx_np_low_q[13:11]}; // R01 R02
            tx_page.page[10:0]  = tx_np_low_q[10:0];
            tx_page.page[47:16] = tx_np_high_q;              // R03
        end
        tx_page.page[`KRPG_PG_PRBS_BIT] = tx_prbs;           // R04
    end

    // Training control fields
    always_comb
    begin
        lt_ctrl.enable        = lt_ctrl_q[`KRPG_LT_EN_BIT];        // R14
        lt_ctrl.dis_max_wait  = lt_ctrl_q[`KRPG_LT_DIS_WAIT_BIT];  // R15
        lt_ctrl.main_steps    = lt_ctrl_q[`KRPG_LT_MAIN_LSB +: 4]; // R16
        lt_ctrl.prepost_steps = lt_ctrl_q[`KRPG_LT_PREPOST_LSB +: 4]; // R17
    end

    // Read decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (s_araddr[13:2])
            `KRPG_IDX_TX_NP_LOW:    rd_val = {16'h0000, tx_np_low_q};
            `KRPG_IDX_TX_NP_HIGH:   rd_val = tx_np_high_q;
            `KRPG_IDX_LP_BASE_LOW:  rd_val = {16'h0000, lp_base_low_q};  // R05
            `KRPG_IDX_LP_BASE_HIGH: rd_val = {2'h0, lp_base_high_q[29:0]}; // R06
            `KRPG_IDX_LP_NP_LOW:    rd_val = {16'h0000, lp_np_low_q};    // R07
            `KRPG_IDX_LP_NP_HIGH:   rd_val = lp_np_high_q;               // R08
            `KRPG_IDX_LP_ADV:       rd_val = adv_word;
            `KRPG_IDX_LT_CTRL:      rd_val = lt_ctrl_q;
            `KRPG_IDX_NP_CTRL:      rd_val = {31'h0, np_en_q};
            default:                rd_hit = 1'b0;
        endcase
    end

    // Bus handshake: address and data held until both are present
    assign s_awready = !aw_held_q && !bvalid_q;
    assign s_wready  = !w_held_q && !bvalid_q;
    assign s_arready = !rvalid_q;
    assign s_bvalid  = bvalid_q;
    assign s_bresp   = bresp_q;
    assign s_rvalid  = rvalid_q;
    assign s_rdata   = rdata_q;
    assign s_rresp   = rresp_q;
    assign do_write  = aw_held_q && w_held_q && !bvalid_q;

    // Next state for bus, software registers and captured pages
    always_comb
    begin
        aw_held_d      = aw_held_q;
        w_held_d       = w_held_q;
        aw_idx_d       = aw_idx_q;
        wdata_d        = wdata_q;
        wstrb_d        = wstrb_q;
        bvalid_d       = bvalid_q;
        bresp_d        = bresp_q;
        rvalid_d       = rvalid_q;
        rdata_d        = rdata_q;
        rresp_d        = rresp_q;
        tx_np_low_d    = tx_np_low_q;
        tx_np_high_d   = tx_np_high_q;
        lt_ctrl_d      = lt_ctrl_q;
        np_en_d        = np_en_q;
        lp_base_low_d  = lp_base_low_q;
        lp_base_high_d = lp_base_high_q;
        lp_np_low_d    = lp_np_low_q;
        lp_np_high_d   = lp_np_high_q;
        lp_fec_d       = lp_fec_q;
        // Capture address and data on their own handshakes
        if (s_awvalid && s_awready)
        begin
            aw_held_d = 1'b1;
            aw_idx_d  = s_awaddr[13:2];
        end
        if (s_wvalid && s_wready)
        begin
            w_held_d = 1'b1;
            wdata_d  = s_wdata;
            wstrb_d  = s_wstrb;
        end
        // Commit write once both halves are held
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `KRPG_RESP_OKAY;
            if (idx_is(aw_idx_q, `KRPG_IDX_TX_NP_LOW))
            begin
                tx_np_low_d = 16'(merge({16'h0000, tx_np_low_q}, wdata_q, wstrb_q));
            end
            else if (idx_is(aw_idx_q, `KRPG_IDX_TX_NP_HIGH))
            begin
                tx_np_high_d = merge(tx_np_high_q, wdata_q, wstrb_q);
            end
            else if (idx_is(aw_idx_q, `KRPG_IDX_LT_CTRL))
            begin
                lt_ctrl_d = merge(lt_ctrl_q, wdata_q, wstrb_q) & `KRPG_LT_CTRL_MASK; // R14 R15 R16 R17
            end
            else if (idx_is(aw_idx_q, `KRPG_IDX_NP_CTRL))
            begin
                np_en_d = wstrb_q[0] ? wdata_q[`KRPG_NP_EN_BIT] : np_en_q;
            end
            else if (!(idx_is(aw_idx_q, `KRPG_IDX_LP_BASE_LOW) || idx_is(aw_idx_q, `KRPG_IDX_LP_BASE_HIGH) ||
                       idx_is(aw_idx_q, `KRPG_IDX_LP_NP_LOW) || idx_is(aw_idx_q, `KRPG_IDX_LP_NP_HIGH) ||
                       idx_is(aw_idx_q, `KRPG_IDX_LP_ADV)))
            begin
                bresp_d = `KRPG_RESP_SLVERR; // Unmapped address
            end
        end
        // Write response retires
        if (bvalid_q && s_bready)
        begin
            bvalid_d = 1'b0;
        end
        // Read answer
        if (s_arvalid && s_arready)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? `KRPG_RESP_OKAY : `KRPG_RESP_SLVERR;
        end
        else if (rvalid_q && s_rready)
        begin
            rvalid_d = 1'b0;
        end
        // Partner pages copied whole on a checked page only
        if (rx_page.valid)                                   // R18
        begin
            if (rx_page.is_base)
            begin
                lp_base_low_d  = rx_page.page[15:0];                        // R05
                lp_base_high_d = {2'h0, rx_page.page[45:16]};               // R06
                lp_fec_d       = {rx_page.page[`KRPG_PG_FEC_REQ_BIT],
                                  rx_page.page[`KRPG_PG_FEC_ABIL_BIT]};     // R11
            end
            else
            begin
                lp_np_low_d  = rx_page.page[15:0];                          // R07
                lp_np_high_d = rx_page.page[47:16];                         // R08
            end
        end
    end

    // Register all state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q      <= 1'b0;
            w_held_q       <= 1'b0;
            aw_idx_q       <= 12'h000;
            wdata_q        <= 32'h0000_0000;
            wstrb_q        <= 4'h0;
            bvalid_q       <= 1'b0;
            bresp_q        <= 2'h0;
            rvalid_q       <= 1'b0;
            rdata_q        <= 32'h0000_0000;
            rresp_q        <= 2'h0;
            tx_np_low_q    <= 16'h0000;
            tx_np_high_q   <= 32'h0000_0000;
            lt_ctrl_q      <= `KRPG_LT_CTRL_RESET; // R14 R15 R16 R17
            np_en_q        <= 1'b0;
            lp_base_low_q  <= 16'h0000;
            lp_base_high_q <= 32'h0000_0000;
            lp_np_low_q    <= 16'h0000;
            lp_np_high_q   <= 32'h0000_0000;
            lp_fec_q       <= 2'h0;
        end
        else
        begin
            aw_held_q      <= aw_held_d;
            w_held_q       <= w_held_d;
            aw_idx_q       <= aw_idx_d;
            wdata_q        <= wdata_d;
            wstrb_q        <= wstrb_d;
            bvalid_q       <= bvalid_d;
            bresp_q        <= bresp_d;
            rvalid_q       <= rvalid_d;
            rdata_q        <= rdata_d;
            rresp_q        <= rresp_d;
            tx_np_low_q    <= tx_np_low_d;
            tx_np_high_q   <= tx_np_high_d;
            lt_ctrl_q      <= lt_ctrl_d;
            np_en_q        <= np_en_d;
            lp_base_low_q  <= lp_base_low_d;
            lp_base_high_q <= lp_base_high_d;
            lp_np_low_q    <= lp_np_low_d;
            lp_np_high_q   <= lp_np_high_d;
            lp_fec_q       <= lp_fec_d;
        end
    end

endmodule

/* inc/krpg_params.svh */
`ifndef KRPG_PARAMS_SVH
`define KRPG_PARAMS_SVH

// Register indices (word addresses); byte address is index * 4
`define KRPG_IDX_TX_NP_LOW        12'h4c5
`define KRPG_IDX_TX_NP_HIGH       12'h4c6
`define KRPG_IDX_LP_BASE_LOW      12'h4c7
`define KRPG_IDX_LP_BASE_HIGH     12'h4c8
`define KRPG_IDX_LP_NP_LOW        12'h4c9
`define KRPG_IDX_LP_NP_HIGH       12'h4ca
`define KRPG_IDX_LP_ADV           12'h4cb
`define KRPG_IDX_LT_CTRL          12'h4d0
`define KRPG_IDX_NP_CTRL          12'h4d8

// Training control fields
`define KRPG_LT_EN_BIT            0
`define KRPG_LT_DIS_WAIT_BIT      1
`define KRPG_LT_MAIN_LSB          4
`define KRPG_LT_PREPOST_LSB       8
`define KRPG_LT_CTRL_RESET        32'h0000_0111
`define KRPG_LT_CTRL_MASK         32'h0000_0fff

// Next-page control register (enable in bit 0)
`define KRPG_NP_EN_BIT            0

// Page field positions
`define KRPG_PG_PRBS_BIT          49
`define KRPG_PG_FEC_ABIL_BIT      46
`define KRPG_PG_FEC_REQ_BIT       47

// AXI response codes
`define KRPG_RESP_OKAY            2'h0
`define KRPG_RESP_SLVERR          2'h2

`endif

/* inc/krpg_pkg.sv */
package krpg_pkg;

    // Full 48-bit page with the internally made pseudo-random bit at 49
    typedef logic [49:0] krpg_page_t;

    // Received page strobe and contents
    typedef struct packed
    {
        logic       valid;   // Page complete and checked
        logic       is_base; // Base page when set, next page otherwise
        krpg_page_t page;    // Page bits
    } krpg_rx_page_t;

    // Outgoing page request to the transmit state machine
    typedef struct packed
    {
        logic       use_np;  // Next page taken from user registers
        krpg_page_t page;    // Page bits
    } krpg_tx_page_t;

    // Training control outputs
    typedef struct packed
    {
        logic       enable;        // Start-up protocol enable
        logic       dis_max_wait;  // Max-wait timer disabled
        logic [3:0] main_steps;    // Steps per main-tap update
        logic [3:0] prepost_steps; // Steps per pre/post-tap update
    } krpg_lt_ctrl_t;

endpackage

/* tb/krpg_regs_monitor.sv */
`include "krpg_params.svh"

// Bus timing and page-field checks
module krpg_regs_monitor
(
    input wire logic                    aclk,           // Clock
    input wire logic                    aresetn,        // Synchronous reset, active low
    input wire logic [13:0]             s_awaddr,       // Write address
    input wire logic                    s_awvalid,      // Write address valid
    input wire logic                    s_awready,      // Write address ready
    input wire logic [31:0]             s_wdata,        // Write data
    input wire logic [3:0]              s_wstrb,        // Write strobes
    input wire logic                    s_wvalid,       // Write data valid
    input wire logic                    s_wready,       // Write data ready
    input wire logic [1:0]              s_bresp,        // Write response
    input wire logic                    s_bvalid,       // Write response valid
    input wire logic                    s_bready,       // Write response ready
    input wire logic                    s_arvalid,      // Read address valid
    input wire logic                    s_arready,      // Read address ready
    input wire logic [31:0]             s_rdata,        // Read data
    input wire logic                    s_rvalid,       // Read data valid
    input wire logic                    s_rready,       // Read data ready
    input wire logic                    tx_prbs,        // Pseudo-random bit in
    input wire krpg_pkg::krpg_tx_page_t tx_page,        // Page to transmit
    input wire krpg_pkg::krpg_lt_ctrl_t lt_ctrl,        // Training controls
    input wire logic [24:0]             supported_tech  // Usable partner techs
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Write taken, and full-word write to one address
    sequence s_write_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence s_wr_to(logic [13:0] a);
        s_write_taken ##0 (s_awaddr == a && s_wstrb == 4'hf);
    endsequence

    property p_write_answer; s_write_taken |-> ##2 s_bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response late");
    property p_read_answer; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read response late");
    property p_resp_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
    property p_rdata_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
    property p_np_gate; !tx_page.use_np |-> tx_page.page[47:0] == 48'h0; endproperty
    a_np_gate: assert property (p_np_gate) else $error("user page leaks while disabled");
    property p_ack_zero; tx_page.use_np |-> !tx_page.page[14]; endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("acknowledge taken from user word");
    property p_prbs; tx_page.page[49] == tx_prbs; endproperty
    a_prbs: assert property (p_prbs) else $error("pseudo-random bit not internal");
    property p_np_high;
        s_wr_to({`KRPG_IDX_TX_NP_HIGH, 2'b00}) |-> ##2 !tx_page.use_np || tx_page.page[47:16] == $past(s_wdata, 2);
    endproperty
    a_np_high: assert property (p_np_high) else $error("high word not mapped to page");
    property p_tech_mask; (supported_tech & 25'h1fffffa) == 25'h0; endproperty
    a_tech_mask: assert property (p_tech_mask) else $error("unsupported tech reported");
    property p_lt_reset; $rose(aresetn) |-> lt_ctrl == 10'b1_0_0001_0001; endproperty
    a_lt_reset: assert property (p_lt_reset) else $error("training reset value wrong");
    property p_lt_write;
        s_wr_to({`KRPG_IDX_LT_CTRL, 2'b00}) |-> ##2
            lt_ctrl == {$past(s_wdata, 2)[0], $past(s_wdata, 2)[1], $past(s_wdata, 2)[7:4], $past(s_wdata, 2)[11:8]};
    endproperty
    a_lt_write: assert property (p_lt_write) else $error("training fields not applied");
endmodule

bind krpg_regs krpg_regs_monitor u_mon (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready,
    .tx_prbs, .tx_page, .lt_ctrl, .supported_tech);

/* tb/krpg_link_partner.sv */
// Link partner: hands over received pages, garbage on the page bus otherwise
module krpg_link_partner
(
    input wire logic                    aclk,    // Clock
    input wire logic                    aresetn, // Synchronous reset, active low
    input wire logic                    send,    // Deliver one page next cycle
    input wire logic                    is_base, // Base page when set
    input wire krpg_pkg::krpg_page_t    page_in, // Page to deliver
    output krpg_pkg::krpg_rx_page_t     rx_page, // Page strobe and bits
    output logic                        tx_prbs  // Pseudo-random bit stream
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lfsr_q; // Free-running noise source

    // Noise steps every cycle; page bits are only meaningful with the strobe
    always @(posedge aclk)
    begin
        if (!aresetn)
            lfsr_q <= 16'hace1;
        else
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        rx_page.valid   <= aresetn && send;
        rx_page.is_base <= send ? is_base : lfsr_q[1];
        rx_page.page    <= send ? page_in : {lfsr_q, lfsr_q, lfsr_q, lfsr_q[1:0]};
    end
    assign tx_prbs = lfsr_q[0];
endmodule

/* tb/krpg_regs_tb.sv */
`include "krpg_params.svh"

// Drives the register bus and the partner, checks reads through a queue
module krpg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    aclk = 0, aresetn = 0;                // Clock and reset
    logic [13:0]             s_awaddr = 0, s_araddr = 0;           // Bus addresses
    logic [31:0]             s_wdata = 0;                          // Write data
    logic [3:0]              s_wstrb = 0;                          // Write strobes
    logic                    s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic                    s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tx_prbs;
    logic [1:0]              s_bresp, s_rresp;                     // Responses
    logic [31:0]             s_rdata;                              // Read data
    logic [24:0]             supported_tech;                       // Usable techs
    krpg_pkg::krpg_rx_page_t rx_page;                              // Partner page
    krpg_pkg::krpg_tx_page_t tx_page;                              // Outgoing page
    krpg_pkg::krpg_lt_ctrl_t lt_ctrl;                              // Training controls
    logic                    pp_send = 0, pp_base = 0;             // Partner request
    krpg_pkg::krpg_page_t    pp_page = 0, p, q;                    // Pages
    logic [65:0]             rq[$], e;                             // Read notes
    logic [1:0]              bq[$];                                // Write notes
    logic [31:0]             v, lo, hi;                            // Random words
    integer                  seed = 15, n_errors = 0, tests_run = 0;

    krpg_regs u_dut (.aclk, .aresetn, .s_awaddr, .s_awprot(3'h0), .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot(3'h0), .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .rx_page, .tx_prbs, .tx_page, .lt_ctrl, .supported_tech);
    krpg_link_partner u_lp (.aclk, .aresetn, .send(pp_send), .is_base(pp_base), .page_in(pp_page), .rx_page,
        .tx_prbs);

    // Clock, 25 ns period
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end

    // Compares one value, counts and reports
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops
    task automatic wrap_up();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One bus write or read, answer noted first
    task automatic axi(input bit wr, input logic [11:0] idx, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] rsp);
        bit done;
        int n;
        logic [2:0] go;
        done = 0;
        if (wr)
            bq.push_back(rsp);
        else
            rq.push_back({rsp, m, d});
        @(posedge aclk);
        if (wr)
        begin
            s_awaddr  <= {idx, 2'b00};
            s_wdata   <= d;
            s_wstrb   <= 4'hf;
            s_awvalid <= 1;
            s_wvalid  <= 1;
            s_bready  <= 1;
        end
        else
        begin
            s_araddr  <= {idx, 2'b00};
            s_arvalid <= 1;
            s_rready  <= 1;
        end
        for (n = 0; n < 64 && !done; n++)
        begin
            @(negedge aclk);
            go   = {s_awvalid && s_awready, s_wvalid && s_wready, s_arvalid && s_arready};
            done = wr ? (s_bvalid && s_bready) : (s_rvalid && s_rready);
            @(posedge aclk);
            if (go[2])
                s_awvalid <= 0;
            if (go[1])
                s_wvalid <= 0;
            if (go[0])
                s_arvalid <= 0;
        end
        s_bready <= 0;
        s_rready <= 0;
        check(done, 1);
    endtask

    // Partner delivers one page
    task automatic send_page(input bit base, input krpg_pkg::krpg_page_t pg);
        @(posedge aclk);
        pp_send <= 1;
        pp_base <= base;
        pp_page <= pg;
        @(posedge aclk);
        pp_send <= 0;
        repeat (4) @(posedge aclk);
    endtask

    // Checks each settled answer against the oldest note
    always @(negedge aclk)
    begin
        if (s_rvalid && s_rready)
        begin
            e = rq.pop_front();
            check({s_rresp, s_rdata & e[63:32]}, {e[65:64], e[31:0] & e[63:32]});
        end
        if (s_bvalid && s_bready)
            check(s_bresp, bq.pop_front());
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        check(lt_ctrl, 10'b1_0_0001_0001);
        axi(0, `KRPG_IDX_LT_CTRL, 32'h111, 32'hffffffff, `KRPG_RESP_OKAY);
        repeat (3)
        begin
            v = $random(seed);
            v[7:4] = (v[7:4] == 4'h0) ? 4'h1 : v[7:4];
            axi(1, `KRPG_IDX_LT_CTRL, v, 0, `KRPG_RESP_OKAY);
            axi(0, `KRPG_IDX_LT_CTRL, v & `KRPG_LT_CTRL_MASK, 32'hffffffff, `KRPG_RESP_OKAY);
            @(negedge aclk);
            check(lt_ctrl, {v[0], v[1], v[7:4], v[11:8]});
        end
        lo = $random(seed);
        hi = $random(seed);
        axi(1, `KRPG_IDX_NP_CTRL, 32'h0, 0, `KRPG_RESP_OKAY);
        axi(1, `KRPG_IDX_TX_NP_LOW, lo, 0, `KRPG_RESP_OKAY);
        axi(1, `KRPG_IDX_TX_NP_HIGH, hi, 0, `KRPG_RESP_OKAY);
        @(negedge aclk);
        check({tx_page.use_np, tx_page.page[47:0]}, 49'h0);
        axi(1, `KRPG_IDX_NP_CTRL, 32'h1, 0, `KRPG_RESP_OKAY);
        @(negedge aclk);
        check({tx_page.use_np, tx_page.page[47:11]}, {1'b1, hi, lo[15], 1'b0, lo[13:11]});
        check(tx_page.page[49], tx_prbs);
        axi(0, `KRPG_IDX_TX_NP_LOW, lo, 32'hffff, `KRPG_RESP_OKAY);
        for (int k = 0; k < 4; k++)
        begin
            p = {$random(seed), $random(seed)};
            p[21] = k[0];
            p[23] = ~k[0];
            q = {$random(seed), $random(seed)};
            send_page(1, p);
            send_page(0, q);
            axi(0, `KRPG_IDX_LP_BASE_LOW, p[15:0], 32'hffff, `KRPG_RESP_OKAY);
            axi(0, `KRPG_IDX_LP_BASE_HIGH, {2'b0, p[45:16]}, 32'hffffffff, `KRPG_RESP_OKAY);
            axi(0, `KRPG_IDX_LP_ADV, {1'b0, p[12:10], p[13], p[47:46], p[45:21]}, 32'hffffffff,
                `KRPG_RESP_OKAY);
            axi(0, `KRPG_IDX_LP_NP_LOW, q[15:0], 32'hf800, `KRPG_RESP_OKAY);
            axi(0, `KRPG_IDX_LP_NP_HIGH, q[47:16], 32'hffffffff, `KRPG_RESP_OKAY);
            check(supported_tech, p[45:21] & 25'h5);
        end
        axi(1, `KRPG_IDX_LP_BASE_LOW, ~p, 0, `KRPG_RESP_OKAY);
        axi(0, `KRPG_IDX_LP_BASE_LOW, p[15:0], 32'hffff, `KRPG_RESP_OKAY);
        axi(0, 12'h4cc, 32'h0, 32'hffffffff, `KRPG_RESP_SLVERR);
        axi(1, 12'h4cc, 32'h0, 0, `KRPG_RESP_SLVERR);
        repeat (2) @(posedge aclk);
        wrap_up();
    end

    // Watchdog
    initial
    begin
        #(25 * 5000);
        n_errors++;
        wrap_up();
    end
endmodule
